// ===== hdl/cbtaf_bit_timing.sv
// Time quantum divider, bit segment sequencer and bus sampler
`timescale 1ns/1ps
module cbtaf_bit_timing (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic [5:0] quantum_prescaler,
  input wire logic [1:0] resync_jump_width,
  input wire logic [2:0] propagation_length,
  input wire logic [2:0] phase_one_length,
  input wire logic [2:0] phase_two_length,
  input wire logic phase_two_select,
  input wire logic triple_sample_select,
  // Synchronised bus line
  input wire logic rx_line,
  // Timing outputs
  output logic tq_tick,
  output logic sample_point,
  output logic bit_strobe,
  output logic bit_value
);
  import cbtaf_pkg::*;
  logic [6:0] q_cnt;
  logic [4:0] pos, ext, cut;
  logic resync_ok, rx_prev;
  logic [1:0] hist;
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction
  // ****************************************
  // Quantum divider
  // ****************************************
  // Six-bit prescaler sets quantum
  // Quantum is 2 x (code+1) clocks
  wire [6:0] q_lim = {quantum_prescaler, 1'b1};
  assign tq_tick = (q_cnt == q_lim);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q_cnt <= 7'h00;
    else q_cnt <= tq_tick ? 7'h00 : q_cnt + 7'h01;
  end
  // ****************************************
  // Segment lengths
  // ****************************************
  // Three-bit prop and phase one fields
  wire [4:0] prop_len = {2'h0, propagation_length} + 5'h01;
  wire [4:0] ph1_len = {2'h0, phase_one_length} + 5'h01;
  // Auto phase two is max of ph1, INFO_PROCESSING_TIME
  wire [4:0] ph2_auto = (ph1_len > IPT_TQ) ? ph1_len : IPT_TQ;
  wire [4:0] ph2_len = phase_two_select ? {2'h0, phase_two_length} + 5'h01 : ph2_auto;
  wire [4:0] sjw_len = {3'h0, resync_jump_width} + 5'h01;
  wire [4:0] samp_pos = prop_len + ph1_len + ext;
  wire [4:0] end_pos = samp_pos + ph2_len - cut;
  // ****************************************
  // Resynchronisation
  // ****************************************
  wire edge_seen = tq_tick & rx_prev & ~rx_line & resync_ok & (pos != 5'h00);
  wire late = edge_seen & (pos <= samp_pos);
  wire early = edge_seen & (pos > samp_pos);
  wire [4:0] err_early = end_pos - pos + 5'h01;
  wire jump = early & (err_early <= sjw_len);
  wire bit_end = tq_tick & (pos == end_pos);
  wire [4:0] late_ext = (pos < sjw_len) ? pos : sjw_len;
  wire [4:0] next_pos = jump ? 5'h01 : (pos == end_pos) ? 5'h00 : pos + 5'h01;
  assign sample_point = tq_tick & (pos == samp_pos) & ~late;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 5'h00;
      ext <= 5'h00;
      cut <= 5'h00;
      resync_ok <= 1'b1;
    end else if (jump | bit_end) begin
      pos <= next_pos;
      ext <= 5'h00;
      cut <= 5'h00;
      resync_ok <= 1'b1;
    end else if (tq_tick) begin
      pos <= next_pos;
      // Phase error limited by jump width
      if (late) ext <= late_ext;
      if (early) cut <= sjw_len;
      if (edge_seen) resync_ok <= 1'b0;
    end
  end
  // ****************************************
  // Bus sampling
  // ****************************************
  // Majority of three quanta or one sample
  wire sampled = triple_sample_select ? maj3(hist[1], hist[0], rx_line) : rx_line;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev <= 1'b1;
      hist <= 2'h3;
      bit_strobe <= 1'b0;
      bit_value <= 1'b1;
    end else begin
      bit_strobe <= sample_point;
      if (tq_tick) rx_prev <= rx_line;
      if (tq_tick) hist <= {hist[0], rx_line};
      if (sample_point) bit_value <= sampled;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  logic [6:0] gap;
  logic [11:0] bit_clks;
  logic seen_tick, seen_end, bit_clean;
  logic [15:0] cfg_d;
  // Any prescaler or segment length field change spoils the bit being measured
  wire [15:0] cfg_now = {quantum_prescaler, propagation_length, phase_one_length, phase_two_length, phase_two_select};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 7'h00;
      bit_clks <= 12'h000;
      seen_tick <= 1'b0;
      seen_end <= 1'b0;
      bit_clean <= 1'b1;
      cfg_d <= 16'h0000;
    end else begin
      gap <= tq_tick ? 7'h00 : gap + 7'h01;
      seen_tick <= seen_tick | tq_tick;
      bit_clks <= bit_end ? 12'h000 : bit_clks + 12'h001;
      seen_end <= seen_end | bit_end;
      cfg_d <= cfg_now;
      bit_clean <= bit_end ? ~jump : bit_clean & ~edge_seen & (cfg_now == cfg_d);
    end
  end
  wire [11:0] exp_clks = 12'(({7'h00, 5'h01 + prop_len + ph1_len + ph2_len}) * ({5'h00, q_lim} + 12'h001));
  a_tq_period: assert property (@(posedge pclk) disable iff (!presetn)
    tq_tick && seen_tick && $stable(quantum_prescaler) |-> gap == q_lim)
    else $error("quantum period wrong");
  a_bit_length: assert property (@(posedge pclk) disable iff (!presetn)
    bit_end && seen_end && bit_clean && ext == 5'h00 && cut == 5'h00 && cfg_now == cfg_d |-> bit_clks + 12'h001 == exp_clks)
    else $error("bit length wrong");
  a_jump_bound: assert property (@(posedge pclk) disable iff (!presetn)
    late |=> ext == ($past(pos) < $past(sjw_len) ? $past(pos) : $past(sjw_len)) && ext <= sjw_len)
    else $error("resync exceeds jump width");
  a_triple_vote: assert property (@(posedge pclk) disable iff (!presetn)
    sample_point && triple_sample_select |=> bit_strobe && bit_value == maj3($past(hist[1]), $past(hist[0]), $past(rx_line)))
    else $error("triple sample vote wrong");
  a_single_samp: assert property (@(posedge pclk) disable iff (!presetn)
    sample_point && !triple_sample_select |=> bit_strobe && bit_value == $past(rx_line))
    else $error("single sample wrong");
  a_ph2_auto: assert property (@(posedge pclk) disable iff (!presetn)
    !phase_two_select |-> ph2_len >= ph1_len && ph2_len >= IPT_TQ && (ph2_len == ph1_len || ph2_len == IPT_TQ))
    else $error("auto phase two wrong");
endmodule

// ===== hdl/cbtaf_match.sv
// One acceptance filter compare against an incoming identifier
`timescale 1ns/1ps
module cbtaf_match (
  // Filter and chosen mask
  input wire logic [15:0] filt_sid,
  input wire logic [15:0] filt_eid,
  input wire logic [15:0] mask_sid,
  input wire logic [15:0] mask_eid,
  input wire logic enable,
  input wire logic sel_ok,
  // Incoming message
  input wire logic [10:0] msg_sid,
  input wire logic [17:0] msg_eid,
  input wire logic msg_ide,
  // Result
  output logic hit
);
  import cbtaf_pkg::*;
  wire [28:0] fid = {filt_sid[15:ID_SID_LSB], filt_sid[1:0], filt_eid};
  wire [28:0] mid = {mask_sid[15:ID_SID_LSB], mask_sid[1:0], mask_eid};
  wire [28:0] xid = {msg_sid, msg_eid};
  // Standard frames carry no extended bits to compare
  wire [28:0] cmask = msg_ide ? mid : {mid[28:18], 18'h00000};
  wire id_ok = ((fid ^ xid) & cmask) == 29'h00000000;
  wire type_ok = ~mask_sid[ID_TYPE_BIT] | (filt_sid[ID_TYPE_BIT] == msg_ide);
  assign hit = enable & sel_ok & id_ok & type_ok;
endmodule

// ===== hdl/cbtaf_pkg.sv
// Shared constants for the CAN bit timing and acceptance filter block
package cbtaf_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFS_CFG1 = 12'h000;
  localparam logic [11:0] OFS_CFG2 = 12'h004;
  localparam logic [11:0] OFS_FEN = 12'h008;
  localparam logic [11:0] OFS_DEST = 12'h00c;
  localparam logic [11:0] OFS_MSEL_LO = 12'h01c;
  localparam logic [11:0] OFS_MSEL_HI = 12'h020;
  localparam logic [11:0] OFS_RX_BUFFER_FULL_FLAG = 12'h024;
  localparam logic [11:0] OFS_STATUS = 12'h028;
  localparam logic [11:0] OFS_MASK = 12'h030;
  localparam logic [11:0] MASK_SPAN = 12'h018;
  localparam logic [11:0] DEST_SPAN = 12'h010;
  localparam logic [4:0] FLT_REGION = 5'h01;
  // ****************************************
  // Field layout
  // ****************************************
  localparam int CFG1_SJW_LSB = 6;
  localparam int CFG2_PH2_LSB = 8;
  localparam int CFG2_WAKE_BIT = 14;
  localparam int CFG2_PH2SEL_BIT = 7;
  localparam int CFG2_TRIPLE_BIT = 6;
  localparam int CFG2_PH1_LSB = 3;
  localparam int ID_SID_LSB = 5;
  localparam int ID_TYPE_BIT = 3;
  localparam logic [15:0] CFG1_WMASK = 16'h00ff;
  localparam logic [15:0] CFG2_WMASK = 16'h47ff;
  localparam logic [15:0] ID_WMASK = 16'hffeb;
  localparam logic [15:0] FEN_RESET = 16'hffff;
  // ****************************************
  // Codes and timing
  // ****************************************
  localparam logic [3:0] DEST_FIFO = 4'hf;
  localparam logic [1:0] MSEL_RSVD = 2'h3;
  localparam logic [4:0] IPT_TQ = 5'h02;
  localparam int NUM_FLT = 16;
  localparam int NUM_MASK = 3;
endpackage

// ===== hdl/cbtaf_top.sv
// CAN bit timing and acceptance filter block with APB register file
`timescale 1ns/1ps
// Summary of operation
// - Jump width code gives one to four quanta
// - Auto phase two is max(ph1, INFO_PROCESSING_TIME)
// - Select bit picks three or one sample
// - Three-bit prop and phase one fields
// - Sixteen enables reset high, zero blocks filter
// - Four-bit destination per filter, four per register
// - Code 1111 to FIFO, else buffer
// - Identifier split over two filter registers
// - Compared message bits must equal filter
// - Mode bit set forces frame type match
// - Two-bit mask selector, code 11 reserved
// - Mask one compares, mask zero ignores
// - Mode clear accepts either frame type
// - Hardware sets full flag, software clears
module cbtaf_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CAN receive pin
  input wire logic can_rx,
  // Decoded message from frame receiver
  input wire logic msg_valid,
  input wire logic [10:0] msg_sid,
  input wire logic [17:0] msg_eid,
  input wire logic msg_ide,
  // Bit timing
  output logic tq_tick,
  output logic sample_point,
  output logic bit_strobe,
  output logic bit_value,
  output logic wake_line_filter_enable,
  // Acceptance result
  output logic accept_valid,
  output logic [3:0] accept_filter,
  output logic [3:0] accept_dest,
  output logic accept_to_fifo,
  output logic [15:0] rx_buffer_full_flag
);
  import cbtaf_pkg::*;
  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0] bit_rate_config_1, bit_rate_config_2, filter_enable;
  logic [15:0] filter_mask_select_low, filter_mask_select_high;
  logic [15:0] filter_dest [4];
  logic [15:0] filter_std_ident [NUM_FLT];
  logic [15:0] filter_ext_ident [NUM_FLT];
  logic [15:0] mask_std_ident [NUM_MASK];
  logic [15:0] mask_ext_ident [NUM_MASK];
  logic rx_meta, rx_sync;
  // ****************************************
  // Address decode
  // ****************************************
  wire aligned = paddr[1:0] == 2'h0;
  wire [11:0] moff = paddr - OFS_MASK;
  wire [11:0] doff = paddr - OFS_DEST;
  wire in_flt = aligned & (paddr[11:7] == FLT_REGION);
  wire in_mask = aligned & (paddr >= OFS_MASK) & (moff < MASK_SPAN);
  wire in_dest = aligned & (paddr >= OFS_DEST) & (doff < DEST_SPAN);
  wire [3:0] fidx = paddr[6:3];
  wire fext = paddr[2];
  wire [1:0] midx = moff[4:3];
  wire mext = moff[2];
  wire [1:0] didx = doff[3:2];
  wire hit_cfg1 = paddr == OFS_CFG1;
  wire hit_cfg2 = paddr == OFS_CFG2;
  wire hit_fen = paddr == OFS_FEN;
  wire hit_mlo = paddr == OFS_MSEL_LO;
  wire hit_mhi = paddr == OFS_MSEL_HI;
  wire hit_full = paddr == OFS_RX_BUFFER_FULL_FLAG;
  wire hit_stat = paddr == OFS_STATUS;
  wire mapped = hit_cfg1 | hit_cfg2 | hit_fen | hit_mlo | hit_mhi | hit_full | hit_stat | in_flt | in_mask | in_dest;
  // ****************************************
  // Bus handshake
  // ****************************************
  wire access = psel & penable;
  wire wr = access & pwrite & mapped;
  wire [15:0] wd = pwdata[15:0];
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  wire [15:0] status_word = {7'h00, accept_to_fifo, accept_dest, accept_filter};
  wire [15:0] flt_word = fext ? filter_ext_ident[fidx] : filter_std_ident[fidx];
  wire [15:0] msk_word = mext ? mask_ext_ident[midx] : mask_std_ident[midx];
  wire [15:0] rd_mux =
    hit_cfg1 ? bit_rate_config_1 :
    hit_cfg2 ? bit_rate_config_2 :
    hit_fen ? filter_enable :
    hit_mlo ? filter_mask_select_low :
    hit_mhi ? filter_mask_select_high :
    hit_full ? rx_buffer_full_flag :
    hit_stat ? status_word :
    in_flt ? flt_word :
    in_mask ? msk_word :
    in_dest ? filter_dest[didx] : 16'h0000;
  // Read data is latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (psel & ~penable) prdata <= {16'h0000, rd_mux};
  end
  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_rate_config_1 <= 16'h0000;
      bit_rate_config_2 <= 16'h0000;
      // Enables come out of reset set
      filter_enable <= FEN_RESET;
      filter_mask_select_low <= 16'h0000;
      filter_mask_select_high <= 16'h0000;
    end else if (wr) begin
      if (hit_cfg1) bit_rate_config_1 <= wd & CFG1_WMASK;
      if (hit_cfg2) bit_rate_config_2 <= wd & CFG2_WMASK;
      if (hit_fen) filter_enable <= wd;
      // Two bits per filter, eight per register
      if (hit_mlo) filter_mask_select_low <= wd;
      if (hit_mhi) filter_mask_select_high <= wd;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) filter_dest[i] <= 16'h0000;
    end else if (wr & in_dest) begin
      filter_dest[didx] <= wd;
    end
  end
  // Standard id with top extended bits, then low extended bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_FLT; i++) begin
        filter_std_ident[i] <= 16'h0000;
        filter_ext_ident[i] <= 16'h0000;
      end
    end else if (wr & in_flt) begin
      if (fext) filter_ext_ident[fidx] <= wd;
      else filter_std_ident[fidx] <= wd & ID_WMASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_MASK; i++) begin
        mask_std_ident[i] <= 16'h0000;
        mask_ext_ident[i] <= 16'h0000;
      end
    end else if (wr & in_mask) begin
      if (mext) mask_ext_ident[midx] <= wd;
      else mask_std_ident[midx] <= wd & ID_WMASK;
    end
  end
  assign wake_line_filter_enable = bit_rate_config_2[CFG2_WAKE_BIT];
  // ****************************************
  // Bit timing
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= can_rx;
      rx_sync <= rx_meta;
    end
  end
  cbtaf_bit_timing u_timing (
    .pclk(pclk),
    .presetn(presetn),
    .quantum_prescaler(bit_rate_config_1[5:0]),
    .resync_jump_width(bit_rate_config_1[CFG1_SJW_LSB +: 2]),
    .propagation_length(bit_rate_config_2[2:0]),
    .phase_one_length(bit_rate_config_2[CFG2_PH1_LSB +: 3]),
    .phase_two_length(bit_rate_config_2[CFG2_PH2_LSB +: 3]),
    .phase_two_select(bit_rate_config_2[CFG2_PH2SEL_BIT]),
    .triple_sample_select(bit_rate_config_2[CFG2_TRIPLE_BIT]),
    .rx_line(rx_sync),
    .tq_tick(tq_tick),
    .sample_point(sample_point),
    .bit_strobe(bit_strobe),
    .bit_value(bit_value)
  );
  // ****************************************
  // Acceptance filters
  // ****************************************
  wire [31:0] msel_flat = {filter_mask_select_high, filter_mask_select_low};
  wire [63:0] dest_flat = {filter_dest[3], filter_dest[2], filter_dest[1], filter_dest[0]};
  wire [15:0] hit_vec;
  for (genvar f = 0; f < NUM_FLT; f++) begin : g_flt
    wire [1:0] msel = msel_flat[f*2 +: 2];
    // Selector picks mask 0, 1 or 2
    wire [15:0] m_sid = (msel == 2'h2) ? mask_std_ident[2] : (msel == 2'h1) ? mask_std_ident[1] : mask_std_ident[0];
    wire [15:0] m_eid = (msel == 2'h2) ? mask_ext_ident[2] : (msel == 2'h1) ? mask_ext_ident[1] : mask_ext_ident[0];
    cbtaf_match u_match (
      .filt_sid(filter_std_ident[f]),
      .filt_eid(filter_ext_ident[f]),
      .mask_sid(m_sid),
      .mask_eid(m_eid),
      .enable(filter_enable[f]),
      .sel_ok(msel != MSEL_RSVD),
      .msg_sid(msg_sid),
      .msg_eid(msg_eid),
      .msg_ide(msg_ide),
      .hit(hit_vec[f])
    );
    a_rsvd_sel: assert property (@(posedge pclk) disable iff (!presetn)
      msel == MSEL_RSVD |-> !hit_vec[f])
      else $error("reserved selector hit");
    a_id_unused: assert property (@(posedge pclk) disable iff (!presetn)
      (filter_std_ident[f] & ~ID_WMASK) == 16'h0000)
      else $error("unused identifier bits set");
  end
  // Lowest numbered hitting filter wins
  function automatic logic [3:0] first_hit(input logic [15:0] v);
    first_hit = 4'h0;
    for (int i = NUM_FLT - 1; i >= 0; i--) begin
      if (v[i]) first_hit = 4'(i);
    end
  endfunction
  wire any_hit = msg_valid & (hit_vec != 16'h0000);
  wire [3:0] win = first_hit(hit_vec);
  wire [3:0] win_dest = dest_flat[win*4 +: 4];
  // Code 1111 routes to the FIFO
  wire win_fifo = win_dest == DEST_FIFO;
  wire [15:0] set_vec = (any_hit & ~win_fifo) ? (16'h0001 << win_dest) : 16'h0000;
  // Writing zero clears a flag, writing one keeps it
  wire [15:0] kept = (wr & hit_full) ? (rx_buffer_full_flag & wd) : rx_buffer_full_flag;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_valid <= 1'b0;
      accept_filter <= 4'h0;
      accept_dest <= 4'h0;
      accept_to_fifo <= 1'b0;
    end else begin
      accept_valid <= any_hit;
      if (any_hit) begin
        accept_filter <= win;
        accept_dest <= win_dest;
        accept_to_fifo <= win_fifo;
      end
    end
  end
  // Set on store wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_buffer_full_flag <= 16'h0000;
    else rx_buffer_full_flag <= kept | set_vec;
  end
  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] fen_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fen_d <= FEN_RESET;
    else fen_d <= filter_enable;
  end
  // Hits seen for the winner check
  logic [15:0] hits_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hits_d <= 16'h0000;
    else hits_d <= msg_valid ? hit_vec : 16'h0000;
  end
  a_lowest_win: assert property (@(posedge pclk) disable iff (!presetn)
    accept_valid |-> hits_d[accept_filter] && (hits_d & ((16'h0001 << accept_filter) - 16'h0001)) == 16'h0000)
    else $error("winning filter wrong");
  a_full_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit_full) |=> (rx_buffer_full_flag & $past(rx_buffer_full_flag)) == $past(rx_buffer_full_flag))
    else $error("full flag lost without clear");
  a_full_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_full && set_vec == 16'h0000 |=> rx_buffer_full_flag == $past(rx_buffer_full_flag & wd))
    else $error("full flag clear wrong");
  a_fifo_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_buffer_full_flag[15])
    else $error("fifo set a buffer flag");
  a_cfg_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (bit_rate_config_1 & ~CFG1_WMASK) == 16'h0000 && (bit_rate_config_2 & ~CFG2_WMASK) == 16'h0000)
    else $error("reserved config bits set");
  a_bad_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_full_set: assert property (@(posedge pclk) disable iff (!presetn)
    accept_valid && !accept_to_fifo |-> rx_buffer_full_flag[accept_dest])
    else $error("full flag not set on store");
  a_enabled_hit: assert property (@(posedge pclk) disable iff (!presetn)
    accept_valid |-> fen_d[accept_filter])
    else $error("disabled filter accepted");
  a_fifo_route: assert property (@(posedge pclk) disable iff (!presetn)
    accept_valid |-> accept_to_fifo == (accept_dest == DEST_FIFO))
    else $error("fifo routing wrong");
  a_no_hit_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(msg_valid && hit_vec != 16'h0000) |=> !accept_valid)
    else $error("accept without hit");
endmodule

// ===== verification/can_bit_timing_and_acceptance_filter_test.sv
// Self-checking bench for the bit timing and acceptance filter block
`timescale 1ns/1ps
module can_bit_timing_and_acceptance_filter_test;
  import cbtaf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, full = '0, dst = '0;
  logic pready, pslverr, can_rx, msg_valid = 0, msg_ide = 0, frame_on = 0, tx_level = 1;
  logic [10:0] msg_sid = '0, fsid = '0, msk = '0, s;
  logic [17:0] msg_eid = '0;
  logic tq_tick, sample_point, bit_strobe, bit_value, accept_valid, accept_to_fifo;
  logic [3:0] accept_filter, accept_dest;
  logic [15:0] rx_buffer_full_flag;
  logic fen0 = 1, ident_type_match_mode = 0, extended_frame_only = 0;
  int n_errors = 0, comparisons = 0, k, n, b, sj, pr, p1, p2, ph2;
  int codes[4] = '{0, 7, 14, 15};
  always #20 pclk = ~pclk;
  cbtaf_node node (.pclk(pclk), .frame_on(frame_on), .tx_level(tx_level), .can_rx(can_rx));
  cbtaf_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_rx(can_rx), .msg_valid(msg_valid), .msg_sid(msg_sid), .msg_eid(msg_eid), .msg_ide(msg_ide),
    .tq_tick(tq_tick), .sample_point(sample_point), .bit_strobe(bit_strobe), .bit_value(bit_value),
    .wake_line_filter_enable(), .accept_valid(accept_valid), .accept_filter(accept_filter),
    .accept_dest(accept_dest), .accept_to_fifo(accept_to_fifo), .rx_buffer_full_flag(rx_buffer_full_flag));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    if (i >= 50) begin n_errors++; conclude(); end
  endtask
  task automatic gap(ref logic sig, output int g);
    int i;
    for (int p = 0; p < 3; p++) begin
      i = 0;
      do begin @(posedge pclk); #1; i++; end while (sig !== 1'b1 && i < 9000);
      if (i >= 9000) begin n_errors++; conclude(); end
    end
    g = i;
  endtask
  task automatic msg(logic [10:0] id, logic ide);
    logic h;
    h = fen0 && ((id & msk) == (fsid & msk)) && (!ident_type_match_mode || ide == extended_frame_only);
    @(posedge pclk);
    msg_valid <= 1; msg_sid <= id; msg_ide <= ide; msg_eid <= 18'($urandom);
    @(posedge pclk);
    msg_valid <= 0;
    #1;
    check("accept_valid", 32'(accept_valid), 32'(h));
    if (h) begin
      if (dst != 15) full[dst] = 1'b1;
      check("accept_dest", 32'(accept_dest), dst);
      check("accept_to_fifo", 32'(accept_to_fifo), 32'(dst == 15));
    end
    check("rx_full", 32'(rx_buffer_full_flag), full);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(59));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_FEN, 0);
    check("fen reset", rd, {16'h0, FEN_RESET});
    apb(0, 12'h002, 0);
    check("unaligned err", 32'(err), 1);
    $display("Reset and decode test done");
    for (k = 0; k < 3; k++) begin
      b = $urandom % 8; sj = $urandom % 4;
      apb(1, OFS_CFG1, (sj << 6) | b);
      apb(0, OFS_CFG1, 0);
      check("cfg1", rd, (sj << 6) | b);
      gap(tq_tick, n);
      check("tq period", n, 2 * (b + 1));
      pr = $urandom % 8; p1 = $urandom % 8; p2 = $urandom % 8;
      apb(1, OFS_CFG2, (p2 << 8) | (k[0] << 7) | ((k == 2) << 6) | (p1 << 3) | pr);
      ph2 = k[0] ? p2 + 1 : (p1 + 1 > 2 ? p1 + 1 : 2);
      gap(bit_strobe, n);
      check("bit period", n, 2 * (b + 1) * (1 + pr + 1 + p1 + 1 + ph2));
    end
    @(posedge pclk);
    tx_level <= 0;
    frame_on <= 1;
    gap(bit_strobe, n);
    check("bit value", 32'(bit_value), 0);
    @(posedge pclk);
    frame_on <= 0;
    $display("Bit timing test done");
    apb(1, OFS_FEN, 1);
    s = 11'($urandom) | 11'h2; fsid = s; msk = 11'h7ff;
    apb(1, 12'h080, {16'h0, s, 5'h0});
    apb(1, OFS_MASK, 32'hffe0);
    foreach (codes[i]) begin
      dst = codes[i];
      apb(1, OFS_DEST, dst);
      msg(s, 0);
    end
    msg(s ^ 11'h1, 0);
    apb(1, OFS_MSEL_LO, 1); msk = 0;
    msg(s ^ 11'h1, 1);
    apb(1, OFS_MSEL_LO, 0); msk = 11'h7ff; ident_type_match_mode = 1;
    apb(1, OFS_MASK, 32'hffe8);
    msg(s, 1);
    msg(s, 0);
    apb(1, 12'h080, {16'h0, s, 5'h8}); extended_frame_only = 1;
    msg(s, 1);
    apb(0, 12'h080, 0);
    check("filter std", rd, {16'h0, s, 5'h8});
    n = $urandom % 65536;
    apb(1, 12'h084, n);
    apb(0, 12'h084, 0);
    check("filter ext", rd, n);
    apb(1, OFS_RX_BUFFER_FULL_FLAG, 0); full = 0;
    apb(1, OFS_FEN, 0); fen0 = 0;
    msg(s, 1);
    $display("Acceptance test done");
    conclude();
  end
endmodule

// ===== verification/cbtaf_node.sv
// Other CAN node driving the shared receive line
`timescale 1ns/1ps
module cbtaf_node (
  // Clock and control
  input wire logic pclk,
  input wire logic frame_on,
  input wire logic tx_level,
  // Bus line
  output logic can_rx = 1'b1
);
  // Line floats recessive when no node drives it
  always_ff @(posedge pclk) begin
    can_rx <= frame_on ? tx_level : 1'b1;
  end
endmodule
